// >>> hdl/vout_setpoint_defs.svh
`ifndef VOUT_SETPOINT_DEFS_SVH
`define VOUT_SETPOINT_DEFS_SVH

// command codes of the three voltage commands
`define CMD_FORMAT      8'h20
`define CMD_SETPOINT    8'h21
`define CMD_UPPER       8'h24

// fixed format byte: mode 000, exponent 10111
`define FORMAT_MODE     3'h0
`define FORMAT_EXP      5'h17

// reset values and limits, mantissa counts of 2^-9 V
`define SETPOINT_RST    16'h0100
`define UPPER_RST_ONE   16'h034d
`define UPPER_RST_HALF  16'h069a
`define SETPOINT_MAXOK  16'h0b00
`define UPPER_MASK      16'h0fff

// feedback ratio encodings, exponent -2
`define SCALE_EXP       5'h1e
`define SCALE_ONE       11'h004
`define SCALE_HALF      11'h002

// bus address of this device; value is arbitrary
`define DEV_ADDR        7'h40
// filler byte sent past the end of a reply
`define FILL_BYTE       8'hff
`define BITS_PER_BYTE   4'h8
`define LAST_BIT        4'h7

`endif

// >>> hdl/vout_setpoint_pkg.sv
package vout_setpoint_pkg;

	// link-side protocol states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_ADDR  = 8'h02,
		ST_AACK  = 8'h04,
		ST_CMD   = 8'h08,
		ST_RXACK = 8'h10,
		ST_WBYTE = 8'h20,
		ST_RBYTE = 8'h40,
		ST_RACK  = 8'h80
	} link_state_t;

	// kinds of request passed from the link to the core
	typedef enum logic [1:0] {
		REQ_SETPOINT = 2'h0,
		REQ_UPPER    = 2'h1,
		REQ_BADCMD   = 2'h2
	} req_kind_t;

endpackage

// >>> hdl/output_voltage_setpoint_regs.sv
`timescale 1ns/1ps
`include "vout_setpoint_defs.svh"

module output_voltage_setpoint_regs (
	input  wire logic        mclk,             // core clock
	input  wire logic        reset_n,          // async reset, active low
	input  wire logic        link_clk,         // bus sampling clock
	input  wire logic        scl_in,           // bus clock pin
	input  wire logic        sda_in,           // bus data pin level
	output logic             sda_out,          // bus data drive value
	output logic             sda_oe,           // bus data drive enable
	output logic             smbalert_out,     // alert drive value
	output logic             smbalert_oe,      // alert drive enable
	input  wire logic        loop_slave_strap, // loop slave configuration pin
	input  wire logic        output_on,        // converter output enabled
	input  wire logic        margin_high_en,   // operation bit 5
	input  wire logic        margin_low_en,    // operation bit 4
	input  wire logic [15:0] vref_trim,        // signed trim counts
	input  wire logic [15:0] margin_high_step, // signed step counts
	input  wire logic [15:0] margin_low_step,  // signed step counts
	input  wire logic [15:0] lower_limit,      // stored lower limit mantissa
	input  wire logic        scale_wr,         // feedback ratio write strobe
	input  wire logic [15:0] scale_wdata,      // feedback ratio write word
	input  wire logic        store_default_all,// nonvolatile store strobe
	input  wire logic        status_clear,     // clears all status flags
	output logic [15:0]      nv_setpoint,      // setpoint saved for storage
	output logic [15:0]      error_amp_reference, // reference counts
	output logic             ratio_half,       // feedback ratio is 0.5
	output logic             loop_slave,       // latched loop slave mode
	output logic             cml_flag,         // communication fault
	output logic             invalid_data_flag,// invalid data written
	output logic             invalid_command_fault, // blocked command used
	output logic             other_fault_flag, // limit clamp other fault
	output logic             voltage_fault_warning_flag, // word summary bit
	output logic             limit_warning_flag // output limit warning
);
	import vout_setpoint_pkg::*;

	// ---------------- core domain ----------------
	logic [15:0] setpoint;
	logic [15:0] upper_limit;
	logic [2:0]  strap_s;
	logic        strap_done;
	logic [2:0]  strap_fill;
	logic [2:0]  req_s;
	logic        req_ack;
	logic [1:0]  pub_ack_s;
	logic        pub_tgl;
	logic [15:0] pub_set;
	logic [15:0] pub_max;
	logic        clamp_q;
	logic [18:0] eff, upper_ref, lower_ref, next_ref;
	logic        clamp_now, ivd_evt, ivc_evt, req_new;
	logic [15:0] wr_value;

	// link domain signals read by the core
	logic        req_tgl;
	req_kind_t   req_kind;
	logic [15:0] req_data;
	logic        pub_ack;

	// scale a mantissa by the feedback ratio into signed reference counts
	function automatic logic [18:0] scaled(input logic [15:0] m, input logic half);
		scaled = half ? {4'h0, m[15:1]} : {3'h0, m};
	endfunction

	// strap passes three flops and is caught once after reset release
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			strap_s    <= 3'h0;
			strap_fill <= 3'h0;
			strap_done <= 1'b0;
			loop_slave <= 1'b0;
		end else begin
			strap_s    <= {strap_s[1:0], loop_slave_strap};
			strap_fill <= {strap_fill[1:0], 1'b1}; // reset zeros in the flops are not the pin
			if (!strap_done && strap_fill[2] && (strap_s[1] == strap_s[2])) begin
				loop_slave <= strap_s[2];
				strap_done <= 1'b1;
			end
		end
	end

	// request toggle from the link, synchronised then edge detected
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			req_s   <= 3'h0;
			req_ack <= 1'b0;
		end else begin
			req_s   <= {req_s[1:0], req_tgl};
			req_ack <= req_s[1];
		end
	end
	assign req_new  = req_s[2] != req_s[1];
	assign wr_value = req_data;

	assign ivd_evt = (req_new && req_kind == REQ_SETPOINT && wr_value > `SETPOINT_MAXOK)
		|| (scale_wr && !(scale_wdata[15:11] == `SCALE_EXP
		&& (scale_wdata[10:0] == `SCALE_ONE || scale_wdata[10:0] == `SCALE_HALF)));
	// blocked command reported by the link
	assign ivc_evt = req_new && req_kind == REQ_BADCMD;

	// setpoint register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			setpoint <= `SETPOINT_RST;
		end else if (req_new && req_kind == REQ_SETPOINT && !loop_slave
			&& wr_value <= `SETPOINT_MAXOK) begin
			if (wr_value > upper_limit)
				setpoint <= upper_limit;
			else if (wr_value < lower_limit)
				setpoint <= lower_limit;
			else
				setpoint <= wr_value;
		end
	end

	// upper limit and feedback ratio
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			upper_limit <= `UPPER_RST_ONE;
			ratio_half  <= 1'b0;
		end else if (scale_wr && !ivd_evt) begin
			// accept ratio one or half only
			ratio_half <= scale_wdata[10:0] == `SCALE_HALF;
			upper_limit <= (scale_wdata[10:0] == `SCALE_HALF) ? `UPPER_RST_HALF : `UPPER_RST_ONE;
		end else if (req_new && req_kind == REQ_UPPER && !loop_slave) begin
			upper_limit <= wr_value & `UPPER_MASK;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			nv_setpoint <= `SETPOINT_RST;
		else if (store_default_all)
			nv_setpoint <= setpoint;
	end

	// effective target recomputed from every input
	always_comb begin
		eff = scaled(setpoint, ratio_half) + {{3{vref_trim[15]}}, vref_trim}
			+ (margin_high_en ? {{3{margin_high_step[15]}}, margin_high_step} : 19'h0)
			+ (margin_low_en ? {{3{margin_low_step[15]}}, margin_low_step} : 19'h0);
		upper_ref = scaled(upper_limit, ratio_half);
		lower_ref = scaled(lower_limit, ratio_half);
		clamp_now = 1'b0;
		next_ref  = eff;
		if (output_on) begin
			if ($signed(eff) > $signed(upper_ref) || upper_limit <= lower_limit) begin
				next_ref  = upper_ref;
				clamp_now = 1'b1;
			end else if ($signed(eff) < $signed(lower_ref)) begin
				next_ref  = lower_ref;
				clamp_now = 1'b1;
			end
		end
	end

	// reference register, negative targets floor at zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			error_amp_reference <= 16'h0000;
			clamp_q             <= 1'b0;
		end else begin
			error_amp_reference <= next_ref[18] ? 16'h0000 : next_ref[15:0];
			clamp_q             <= clamp_now;
		end
	end

	// sticky status flags, a set beats a simultaneous clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cml_flag                   <= 1'b0;
			invalid_data_flag          <= 1'b0;
			invalid_command_fault      <= 1'b0;
			other_fault_flag           <= 1'b0;
			voltage_fault_warning_flag <= 1'b0;
			limit_warning_flag         <= 1'b0;
		end else begin
			cml_flag <= ivd_evt || ivc_evt || (cml_flag && !status_clear);
			invalid_data_flag <= ivd_evt || (invalid_data_flag && !status_clear);
			invalid_command_fault <= ivc_evt || (invalid_command_fault && !status_clear);
			other_fault_flag <= (clamp_now && !clamp_q) || (other_fault_flag && !status_clear);
			voltage_fault_warning_flag <= (clamp_now && !clamp_q)
				|| (voltage_fault_warning_flag && !status_clear);
			limit_warning_flag <= (clamp_now && !clamp_q) || (limit_warning_flag && !status_clear);
		end
	end

	// alert pulls low while any flag stands
	assign smbalert_out = 1'b0;
	assign smbalert_oe  = cml_flag || invalid_command_fault || other_fault_flag
		|| voltage_fault_warning_flag || limit_warning_flag;

	// publish register words to the link with a toggle handshake
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pub_ack_s <= 2'h0;
			pub_tgl   <= 1'b0;
			pub_set   <= `SETPOINT_RST;
			pub_max   <= `UPPER_RST_ONE;
		end else begin
			pub_ack_s <= {pub_ack_s[0], pub_ack};
			if (pub_tgl == pub_ack_s[1] && (pub_set != setpoint || pub_max != upper_limit)) begin
				pub_set <= setpoint;
				pub_max <= upper_limit;
				pub_tgl <= !pub_tgl;
			end
		end
	end

	// ---------------- link domain ----------------
	link_state_t state;
	logic [2:0]  scl_s, sda_s;
	logic        scl_f, sda_f, scl_q, sda_q;
	logic [1:0]  ls_s, rack_s;
	logic [2:0]  pub_s;
	logic [15:0] shadow_set, shadow_max;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg, cmd, lo_byte;
	logic [7:0]  first_reply, next_reply;
	logic [1:0]  byte_idx;
	logic        rw, ack_go, more;
	logic        scl_rise, scl_fall, start_c, stop_c, busy, cmd_ours;

	// pins pass three flops, level moves when the last two agree
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
			if (scl_s[1] == scl_s[2])
				scl_f <= scl_s[2];
			if (sda_s[1] == sda_s[2])
				sda_f <= sda_s[2];
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end
	assign scl_rise = scl_f && !scl_q;
	assign scl_fall = !scl_f && scl_q;
	assign start_c  = scl_f && scl_q && sda_q && !sda_f;
	assign stop_c   = scl_f && scl_q && !sda_q && sda_f;

	// crossings into the link: loop slave level, request ack, published words
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			ls_s       <= 2'h0;
			rack_s     <= 2'h0;
			pub_s      <= 3'h0;
			pub_ack    <= 1'b0;
			shadow_set <= `SETPOINT_RST;
			shadow_max <= `UPPER_RST_ONE;
		end else begin
			ls_s   <= {ls_s[0], loop_slave};
			rack_s <= {rack_s[0], req_ack};
			pub_s  <= {pub_s[1:0], pub_tgl};
			if (pub_s[2] != pub_s[1]) begin
				shadow_set <= pub_set;
				shadow_max <= pub_max;
				pub_ack    <= pub_s[1];
			end
		end
	end
	assign busy     = req_tgl != rack_s[1];
	assign cmd_ours = cmd == `CMD_FORMAT || cmd == `CMD_SETPOINT || cmd == `CMD_UPPER;

	// reply byte for a read, words low byte first
	function automatic logic [7:0] reply(input logic [7:0] c, input logic [1:0] idx,
		input logic [15:0] sp, input logic [15:0] mx);
		reply = `FILL_BYTE;
		case (c)
			`CMD_FORMAT: if (idx == 2'h0) reply = {`FORMAT_MODE, `FORMAT_EXP};
			`CMD_SETPOINT: if (idx == 2'h0) reply = sp[7:0]; else if (idx == 2'h1) reply = sp[15:8];
			`CMD_UPPER: if (idx == 2'h0) reply = mx[7:0]; else if (idx == 2'h1) reply = mx[15:8];
			default: reply = `FILL_BYTE;
		endcase
	endfunction

	// first and following reply bytes, bit 7 goes out first
	assign first_reply = reply(cmd, 2'h0, shadow_set, shadow_max);
	assign next_reply  = reply(cmd, byte_idx, shadow_set, shadow_max);

	// bus slave: address, command, data bytes and acknowledges
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= ST_IDLE;
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			cmd      <= 8'h00;
			lo_byte  <= 8'h00;
			byte_idx <= 2'h0;
			rw       <= 1'b0;
			ack_go   <= 1'b0;
			more     <= 1'b0;
			sda_oe   <= 1'b0;
			req_tgl  <= 1'b0;
			req_kind <= REQ_SETPOINT;
			req_data <= 16'h0000;
		end else if (start_c) begin
			state   <= ST_ADDR;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (stop_c) begin
			state  <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_CMD, ST_WBYTE: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR) begin
							rw     <= shreg[0];
							ack_go <= shreg[7:1] == `DEV_ADDR && !busy
								&& (!shreg[0] || (cmd_ours && !ls_s[1]));
							sda_oe <= shreg[7:1] == `DEV_ADDR && !busy
								&& (!shreg[0] || (cmd_ours && !ls_s[1]));
							byte_idx <= 2'h0;
							state  <= ST_AACK;
						end else if (state == ST_CMD) begin
							cmd      <= shreg;
							byte_idx <= 2'h0;
							// blocked commands are NACKed and reported
							if (ls_s[1] && (shreg == `CMD_FORMAT || shreg == `CMD_SETPOINT
								|| shreg == `CMD_UPPER)) begin
								req_kind <= REQ_BADCMD;
								req_tgl  <= !req_tgl;
								sda_oe   <= 1'b0;
								ack_go   <= 1'b0;
							end else begin
								sda_oe <= shreg == `CMD_FORMAT || shreg == `CMD_SETPOINT
									|| shreg == `CMD_UPPER;
								ack_go <= shreg == `CMD_FORMAT || shreg == `CMD_SETPOINT
									|| shreg == `CMD_UPPER;
							end
							state <= ST_RXACK;
						end else begin
							byte_idx <= byte_idx + 2'h1;
							if (byte_idx == 2'h0 && cmd != `CMD_FORMAT) begin
								lo_byte <= shreg;
								sda_oe  <= 1'b1;
								ack_go  <= 1'b1;
							end else if (byte_idx == 2'h1) begin
								// oversized setpoint NACKed, core flags it
								sda_oe   <= !(cmd == `CMD_SETPOINT && {shreg, lo_byte} > `SETPOINT_MAXOK);
								ack_go   <= 1'b0;
								req_kind <= (cmd == `CMD_SETPOINT) ? REQ_SETPOINT : REQ_UPPER;
								req_data <= {shreg, lo_byte};
								req_tgl  <= !req_tgl;
							end else begin
								sda_oe <= 1'b0;
								ack_go <= 1'b0;
							end
							state <= ST_RXACK;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (!ack_go) begin
							sda_oe <= 1'b0;
							state  <= ST_IDLE;
						end else if (rw) begin
							shreg  <= first_reply;
							sda_oe <= !first_reply[7];
							state  <= ST_RBYTE;
						end else begin
							sda_oe <= 1'b0;
							state  <= ST_CMD;
						end
					end
				end
				ST_RXACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state  <= ack_go ? ST_WBYTE : ST_IDLE;
					end
				end
				ST_RBYTE: begin
					if (scl_fall) begin
						if (bit_cnt == `LAST_BIT) begin
							sda_oe   <= 1'b0;
							bit_cnt  <= 4'h0;
							byte_idx <= byte_idx + 2'h1;
							state    <= ST_RACK;
						end else begin
							shreg   <= {shreg[6:0], 1'b0};
							sda_oe  <= !shreg[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise)
						more <= !sda_f;
					else if (scl_fall) begin
						if (more) begin
							shreg  <= next_reply;
							sda_oe <= !next_reply[7];
							state  <= ST_RBYTE;
						end else
							state <= ST_IDLE;
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end
	assign sda_out = 1'b0;

endmodule // output_voltage_setpoint_regs

// >>> dv/vout_regs_monitor.sv
`timescale 1ns/1ps

module vout_regs_monitor (
	input wire logic        mclk,                       // core clock
	input wire logic        reset_n,                    // async reset, active low
	input wire logic        sda_out,                    // data drive value
	input wire logic        smbalert_out,               // alert drive value
	input wire logic        smbalert_oe,                // alert drive enable
	input wire logic        loop_slave_strap,           // loop slave pin
	input wire logic        output_on,                  // output enabled
	input wire logic        margin_high_en,             // margin high gate
	input wire logic        margin_low_en,              // margin low gate
	input wire logic [15:0] vref_trim,                  // trim counts
	input wire logic [15:0] margin_high_step,           // step counts
	input wire logic [15:0] lower_limit,                // lower limit
	input wire logic        status_clear,               // flag clear
	input wire logic        scale_wr,                   // ratio write
	input wire logic [15:0] error_amp_reference,        // reference counts
	input wire logic        loop_slave,                 // latched mode
	input wire logic        cml_flag,                   // comm fault
	input wire logic        invalid_data_flag,          // invalid data
	input wire logic        invalid_command_fault,      // blocked command
	input wire logic        other_fault_flag,           // other fault
	input wire logic        voltage_fault_warning_flag, // summary bit
	input wire logic        limit_warning_flag          // limit warning
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic any_flag;

	// any sticky flag set
	assign any_flag = cml_flag | invalid_data_flag | invalid_command_fault | other_fault_flag
		| voltage_fault_warning_flag | limit_warning_flag;

	ref_upper_a: assert property ($past(output_on) && output_on |-> error_amp_reference <= 16'h034d)
		else $error("reference above upper limit");
	ref_lower_a: assert property ($past(output_on) && output_on && $stable(lower_limit) &&
		lower_limit < 16'h0119 |-> error_amp_reference >= lower_limit) else $error("reference below lower");
	margin_add_a: assert property (!output_on && $rose(margin_high_en) && !margin_low_en &&
		$stable(vref_trim) |=> error_amp_reference == $past(error_amp_reference) + $past(margin_high_step))
		else $error("margin step not added");
	clamp_flags_a: assert property ($rose(other_fault_flag) |-> voltage_fault_warning_flag && limit_warning_flag)
		else $error("clamp flags incomplete");
	clear_flags_a: assert property (status_clear && !output_on && !scale_wr |=> !other_fault_flag)
		else $error("clamp flag survived clear");
	alert_src_a: assert property (any_flag |-> ##[0:2] smbalert_oe)
		else $error("alert not raised");
	odrain_low_a: assert property (sda_out == 1'b0 && smbalert_out == 1'b0)
		else $error("open drain value high");
	cml_pair_a: assert property ($rose(invalid_data_flag) |-> cml_flag)
		else $error("invalid data without cml");
	loop_hold_a: assert property (loop_slave |=> loop_slave)
		else $error("loop slave mode dropped");
	loop_strap_a: assert property ($rose(loop_slave) |-> loop_slave_strap)
		else $error("loop slave without strap");

	// main scenarios
	cover property ($rose(other_fault_flag));
	cover property ($rose(invalid_data_flag));
	cover property ($rose(invalid_command_fault));
endmodule // vout_regs_monitor

bind output_voltage_setpoint_regs vout_regs_monitor mon (.mclk, .reset_n, .sda_out, .smbalert_out, .smbalert_oe,
	.loop_slave_strap, .output_on, .margin_high_en, .margin_low_en, .vref_trim, .margin_high_step, .lower_limit,
	.status_clear, .scale_wr, .error_amp_reference, .loop_slave, .cml_flag, .invalid_data_flag,
	.invalid_command_fault, .other_fault_flag, .voltage_fault_warning_flag, .limit_warning_flag);

// >>> dv/pmbus_host_model.sv
`timescale 1ns/1ps
`include "vout_setpoint_defs.svh"

module pmbus_host_model (
	output logic      scl_in,   // bus clock from host
	output logic      sda_pull, // host pulls data low
	input  wire logic sda_in    // resolved data level
);
	localparam time HALF = 150ns;

	// bus idles released, pull-up holds it high
	initial begin
		scl_in = 1'b1;
		sda_pull = 1'b0;
	end

	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		#(HALF/3) sda_pull = ~b;
		#HALF scl_in = 1'b1;
		s = sda_in;
		#HALF scl_in = 1'b0;
	endtask

	// a released bit reads the device, so one task serves both ways
	task automatic byte_io(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
			r[i] = s;
		end
		bit_io(last, s);
		ack = ~s;
	endtask

	task automatic start();
		#(HALF/3) sda_pull = 1'b0;
		#HALF scl_in = 1'b1;
		#HALF sda_pull = 1'b1;
		#HALF scl_in = 1'b0;
	endtask

	// long gap after stop lets the core finish the write
	task automatic stop();
		#(HALF/3) sda_pull = 1'b1;
		#HALF scl_in = 1'b1;
		#HALF sda_pull = 1'b0;
		#(HALF*4);
	endtask

	// n bytes of the word, low byte first, stop after any refusal
	task automatic wr(input logic [7:0] cmd, input logic [15:0] wd, input int n, output logic [3:0] ak);
		logic [7:0] r;
		ak = 4'h0;
		start();
		byte_io({`DEV_ADDR, 1'b0}, 1'b1, r, ak[3]);
		if (ak[3]) byte_io(cmd, 1'b1, r, ak[2]);
		if (ak[2] && n > 0) byte_io(wd[7:0], 1'b1, r, ak[1]);
		if (ak[1] && n > 1) byte_io(wd[15:8], 1'b1, r, ak[0]);
		stop();
	endtask

	// word read ending with a host refusal on the last byte
	task automatic rd(input logic [7:0] cmd, output logic [15:0] rw, output logic ok);
		logic a0;
		logic a1;
		logic a2;
		start();
		byte_io({`DEV_ADDR, 1'b0}, 1'b1, rw[7:0], a0);
		byte_io(cmd, 1'b1, rw[7:0], a1);
		start();
		byte_io({`DEV_ADDR, 1'b1}, 1'b1, rw[7:0], a2);
		byte_io(8'hff, 1'b0, rw[7:0], ok);
		byte_io(8'hff, 1'b1, rw[15:8], ok);
		ok = a0 & a1 & a2;
		stop();
	endtask
endmodule // pmbus_host_model

// >>> dv/output_voltage_setpoint_regs_test.sv
`timescale 1ns/1ps
`include "vout_setpoint_defs.svh"

module output_voltage_setpoint_regs_test;
	import vout_setpoint_pkg::*;
	typedef struct packed {
		logic [15:0] val; // word written
		logic        ack; // high byte accepted
		logic [15:0] sp;  // setpoint afterwards
	} row_t;
	row_t        rows [5] = '{'{16'h0190, 1'b1, 16'h0190}, '{16'h0b00, 1'b1, 16'h034d},
		'{16'h0b01, 1'b0, 16'h034d}, '{16'h0032, 1'b1, 16'h0064}, '{16'h02bc, 1'b1, 16'h02bc}};
	logic [7:0]  codes [3] = '{`CMD_FORMAT, `CMD_SETPOINT, `CMD_UPPER};
	logic        mclk, reset_n, link_clk, scl_in, sda_in, sda_pull, sda_out, sda_oe, smbalert_out, smbalert_oe;
	logic        loop_slave_strap, output_on, margin_high_en, margin_low_en, scale_wr, store_default_all;
	logic        status_clear, ratio_half, loop_slave, cml_flag, invalid_data_flag, invalid_command_fault;
	logic        other_fault_flag, voltage_fault_warning_flag, limit_warning_flag;
	logic [15:0] vref_trim, margin_high_step, margin_low_step, lower_limit, scale_wdata;
	logic [15:0] nv_setpoint, error_amp_reference;
	int          err_count = 0;
	int          checks = 0;
	int          cycles = 0;

	// open drain data line with pull-up
	assign sda_in = ~(sda_pull | sda_oe);

	pmbus_host_model host (.scl_in, .sda_pull, .sda_in);

	output_voltage_setpoint_regs dut (.mclk, .reset_n, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe,
		.smbalert_out, .smbalert_oe, .loop_slave_strap, .output_on, .margin_high_en, .margin_low_en, .vref_trim,
		.margin_high_step, .margin_low_step, .lower_limit, .scale_wr, .scale_wdata, .store_default_all,
		.status_clear, .nv_setpoint, .error_amp_reference, .ratio_half, .loop_slave, .cml_flag,
		.invalid_data_flag, .invalid_command_fault, .other_fault_flag, .voltage_fault_warning_flag,
		.limit_warning_flag);

	// core clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// link clock, unrelated phase
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	// cycle ceiling against hangs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// one-cycle strobe: bit 0 clear, bit 1 store, bit 2 ratio write
	task automatic pulse(input logic [2:0] sel);
		{scale_wr, store_default_all, status_clear} = sel;
		tick(1);
		{scale_wr, store_default_all, status_clear} = 3'h0;
		tick(3);
	endtask

	task automatic do_reset(input logic strap);
		tick(1);
		reset_n = 1'b0;
		loop_slave_strap = strap;
		tick(12);
		reset_n = 1'b1;
		tick(10);
	endtask

	// main sequence
	initial begin
		logic [3:0]  ak;
		logic [15:0] rw;
		logic        ok;
		{reset_n, loop_slave_strap, output_on, margin_high_en, margin_low_en} = 5'h00;
		{scale_wr, store_default_all, status_clear} = 3'h0;
		{vref_trim, margin_high_step, margin_low_step, scale_wdata} = 64'h0;
		lower_limit = 16'h0064;
		do_reset(1'b0);
		// ordinary setpoint writes, output off
		foreach (rows[i]) begin
			host.wr(`CMD_SETPOINT, rows[i].val, 2, ak);
			tick(200);
			chk({15'h0, ak[0]}, {15'h0, rows[i].ack});
			chk(error_amp_reference, rows[i].sp);
			host.rd(`CMD_SETPOINT, rw, ok);
			tick(2);
			chk(rw, rows[i].sp);
		end
		chk({13'h0, cml_flag, invalid_data_flag, smbalert_oe}, 16'h0007);
		pulse(3'h1);
		chk({15'h0, smbalert_oe}, 16'h0000);
		pulse(3'h2);
		chk(nv_setpoint, 16'h02bc);
		// format byte refuses data and reads fixed
		host.wr(`CMD_FORMAT, 16'h0055, 1, ak);
		tick(200);
		chk({12'h0, ak}, 16'h000c);
		host.rd(`CMD_FORMAT, rw, ok);
		tick(2);
		chk(rw, {`FILL_BYTE, `FORMAT_MODE, `FORMAT_EXP});
		chk({15'h0, ok}, 16'h0001);
		// margin steps gated by the operation bits
		margin_high_step = 16'h0010;
		margin_low_step = 16'hfff0;
		tick(2);
		margin_high_en = 1'b1;
		tick(3);
		chk(error_amp_reference, 16'h02cc);
		margin_low_en = 1'b1;
		tick(3);
		chk(error_amp_reference, 16'h02bc);
		// trim pushes target past upper while on
		vref_trim = 16'h012c;
		output_on = 1'b1;
		tick(4);
		chk(error_amp_reference, 16'h034d);
		chk({12'h0, other_fault_flag, voltage_fault_warning_flag, limit_warning_flag, smbalert_oe}, 16'h000f);
		host.wr(`CMD_UPPER, 16'h0258, 2, ak);
		tick(200);
		chk(error_amp_reference, 16'h0258);
		// trim drags the target under the lower limit, then equal limits let upper win
		vref_trim = 16'hfd76;
		tick(4);
		chk(error_amp_reference, 16'h0064);
		lower_limit = 16'h0258;
		tick(4);
		chk(error_amp_reference, 16'h0258);
		{output_on, margin_high_en, margin_low_en, vref_trim} = 19'h0;
		lower_limit = 16'h0064;
		tick(2);
		pulse(3'h1);
		// half ratio reloads the upper default
		scale_wdata = {`SCALE_EXP, `SCALE_HALF};
		pulse(3'h4);
		chk({15'h0, ratio_half}, 16'h0001);
		chk(error_amp_reference, 16'h015e);
		host.rd(`CMD_UPPER, rw, ok);
		tick(2);
		chk(rw, `UPPER_RST_HALF);
		scale_wdata = {`SCALE_EXP, 11'h003};
		pulse(3'h4);
		chk({13'h0, cml_flag, invalid_data_flag, ratio_half}, 16'h0007);
		// reset values
		do_reset(1'b0);
		chk(error_amp_reference, `SETPOINT_RST);
		chk(nv_setpoint, `SETPOINT_RST);
		chk({10'h0, cml_flag, invalid_data_flag, other_fault_flag, loop_slave, smbalert_oe, ratio_half}, 16'h0);
		host.rd(`CMD_UPPER, rw, ok);
		tick(2);
		chk(rw, `UPPER_RST_ONE);
		// loop slave blocks all three commands
		do_reset(1'b1);
		foreach (codes[i]) begin
			host.wr(codes[i], 16'h0190, 2, ak);
			tick(100);
			chk({12'h0, ak}, 16'h0008);
		end
		host.rd(`CMD_SETPOINT, rw, ok);
		chk({15'h0, ok}, 16'h0000);
		chk({13'h0, loop_slave, invalid_command_fault, smbalert_oe}, 16'h0007);
		chk(error_amp_reference, `SETPOINT_RST);
		print_verdict();
	end
endmodule // output_voltage_setpoint_regs_test
